// [design/sfsa_pkg.sv]
// constants and types shared by the simd / floating-point alias state block
// assumes one core clock and an execution pipeline that issues one request
package sfsa_pkg;
	localparam int NUM_REGS      = 8;
	localparam int REG_W         = 80;
	localparam int SIMD_W        = 64;
	localparam int EXP_LSB       = 64;
	localparam int EXP_MSB       = 79;
	localparam int TOS_W         = 3;
	localparam int FEAT_SIMD_BIT = 23;
	localparam int EMU_FLAG_BIT  = 2;
	localparam int NUMERIC_VECTOR = 16;
	localparam logic [1:0]  TAG_VALID = 2'h0;
	localparam logic [1:0]  TAG_EMPTY = 2'h3;
	localparam logic [15:0] TAG_RESET = 16'hFFFF;
	localparam logic [15:0] EXP_ONES  = 16'hFFFF;
	localparam logic [2:0]  TOS_RESET = 3'h0;
	localparam logic [7:0]  FAULT_VEC_UD = 8'h06;
	localparam logic [7:0]  FAULT_VEC_MF = 8'h10;

	typedef enum logic [2:0] {
		SFSA_OP_NONE  = 3'b000,
		SFSA_OP_SIMD  = 3'b001,
		SFSA_OP_EMPTY = 3'b010,
		SFSA_OP_FP    = 3'b011,
		SFSA_OP_SAVE  = 3'b100
	} sfsa_op_t;

	typedef enum logic [1:0] {
		SFSA_RES_DONE  = 2'b00,
		SFSA_RES_UD    = 2'b01,
		SFSA_RES_NUMER = 2'b10
	} sfsa_res_t;
endpackage

// [design/sfsa_regfile.sv]
// physical floating-point register array, eight 80-bit entries
// assumes at most one write per cycle and an index already resolved
module sfsa_regfile (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        wr_en_in,
	input  wire logic [2:0]  wr_idx_in,
	input  wire logic [79:0] wr_data_in,
	input  wire logic [2:0]  rd_idx_in,
	output logic      [79:0] rd_data_out
);
	logic [79:0] mem      [8];
	logic [79:0] next_mem [8];

	always_comb begin
		for (int i = 0; i < sfsa_pkg::NUM_REGS; i++) begin
			next_mem[i] = mem[i];
		end
		if (wr_en_in) begin
			next_mem[wr_idx_in] = wr_data_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < sfsa_pkg::NUM_REGS; i++) begin
				mem[i] <= 80'h0000_0000_0000_0000_0000;
			end
		end else begin
			for (int i = 0; i < sfsa_pkg::NUM_REGS; i++) begin
				mem[i] <= next_mem[i];
			end
		end
	end

	assign rd_data_out = mem[rd_idx_in];
endmodule

// [design/sfsa_top.sv]
// alias state keeper: tag word, stack top and the shared register array
// assumes requests come from the core pipeline on mclk_in, one per cycle
module sfsa_top (
	input  wire logic        mclk_in,
	input  wire logic        rstn_in,
	input  wire logic        req_valid_in,
	input  wire logic [2:0]  req_op_in,
	input  wire logic        req_supported_in,
	input  wire logic        simd_wr_in,
	input  wire logic [2:0]  simd_idx_in,
	input  wire logic [63:0] simd_data_in,
	input  wire logic        fp_wr_in,
	input  wire logic [2:0]  fp_idx_in,
	input  wire logic [79:0] fp_data_in,
	input  wire logic [15:0] fp_tag_in,
	input  wire logic [2:0]  fp_tos_in,
	input  wire logic        fp_state_wr_in,
	input  wire logic        fpu_emulation_flag_in,
	input  wire logic        fp_exc_pending_in,
	input  wire logic [2:0]  rd_idx_in,
	output logic      [79:0] rd_data_out,
	output logic      [63:0] simd_rd_data_out,
	output logic      [15:0] tag_word_out,
	output logic      [2:0]  stack_top_pointer_out,
	output logic             done_out,
	output logic             invalid_opcode_fault_out,
	output logic             numeric_error_out,
	output logic      [7:0]  fault_vector_out,
	output logic      [31:0] feature_general_reg_d_out
);
	////////////////////////////////////////////////////////////////////////

	logic [15:0] tag_word;
	logic [15:0] next_tag_word;
	logic [2:0]  stack_top_pointer;
	logic [2:0]  next_tos;
	logic        done;
	logic        next_done;
	logic        ud;
	logic        next_ud;
	logic        mf;
	logic        next_mf;
	logic [7:0]  vec;
	logic [7:0]  next_vec;
	logic        wr_en;
	logic [2:0]  wr_idx;
	logic [79:0] wr_data;
	logic        is_simd;
	logic        is_empty;
	logic        simd_class;
	logic        fault_ud;
	logic        fault_mf;
	logic        simd_exec;

	function automatic logic [15:0] fill_tags(input logic [1:0] code);
		logic [15:0] t;
		t = 16'h0000;
		for (int i = 0; i < sfsa_pkg::NUM_REGS; i++) begin
			t[2*i +: 2] = code;
		end
		return t;
	endfunction

	assign is_simd    = req_valid_in && (req_op_in == sfsa_pkg::SFSA_OP_SIMD);
	assign is_empty   = req_valid_in && (req_op_in == sfsa_pkg::SFSA_OP_EMPTY);
	assign simd_class = is_simd || is_empty;
	assign fault_ud   = simd_class
		&& (fpu_emulation_flag_in || !req_supported_in);
	assign fault_mf   = simd_class && !fault_ud && fp_exc_pending_in;
	assign simd_exec  = simd_class && !fault_ud && !fault_mf;

	////////////////////////////////////////////////////////////////////////
	// shared register write
	always_comb begin
		wr_en   = 1'b0;
		wr_idx  = 3'h0;
		wr_data = 80'h0000_0000_0000_0000_0000;
		if (simd_exec && is_simd && simd_wr_in) begin
			wr_en   = 1'b1;
			wr_idx  = simd_idx_in;
			wr_data = {sfsa_pkg::EXP_ONES, simd_data_in};
		end else if (req_valid_in && fp_wr_in
			&& req_op_in == sfsa_pkg::SFSA_OP_FP) begin
			wr_en   = 1'b1;
			wr_idx  = fp_idx_in;
			wr_data = fp_data_in;
		end
	end

	sfsa_regfile u_regfile (
		.mclk_in     (mclk_in),
		.rstn_in     (rstn_in),
		.wr_en_in    (wr_en),
		.wr_idx_in   (wr_idx),
		.wr_data_in  (wr_data),
		.rd_idx_in   (rd_idx_in),
		.rd_data_out (rd_data_out)
	);

	////////////////////////////////////////////////////////////////////////

	always_comb begin
		next_tag_word = tag_word;
		next_tos      = stack_top_pointer;
		next_done     = 1'b0;
		next_ud       = 1'b0;
		next_mf       = 1'b0;
		next_vec      = vec;
		if (fault_ud) begin
			next_ud  = 1'b1;
			next_vec = sfsa_pkg::FAULT_VEC_UD;
		end else if (fault_mf) begin
			next_mf  = 1'b1;
			next_vec = sfsa_pkg::FAULT_VEC_MF;
		end else if (simd_exec && is_simd) begin
			next_done     = 1'b1;
			next_tag_word = fill_tags(sfsa_pkg::TAG_VALID);
			next_tos      = sfsa_pkg::TOS_RESET;
		end else if (simd_exec && is_empty) begin
			next_done     = 1'b1;
			next_tag_word = fill_tags(sfsa_pkg::TAG_EMPTY);
		end else if (req_valid_in) begin
			next_done = 1'b1;
			if (req_op_in == sfsa_pkg::SFSA_OP_FP && fp_state_wr_in) begin
				next_tag_word = fp_tag_in;
				next_tos      = fp_tos_in;
			end
		end
	end

	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tag_word <= sfsa_pkg::TAG_RESET;
			stack_top_pointer      <= sfsa_pkg::TOS_RESET;
			done     <= 1'b0;
			ud       <= 1'b0;
			mf       <= 1'b0;
			vec      <= 8'h00;
		end else begin
			tag_word <= next_tag_word;
			stack_top_pointer      <= next_tos;
			done     <= next_done;
			ud       <= next_ud;
			mf       <= next_mf;
			vec      <= next_vec;
		end
	end

	assign tag_word_out             = tag_word;
	assign stack_top_pointer_out    = stack_top_pointer;
	assign done_out                 = done;
	assign invalid_opcode_fault_out = ud;
	assign numeric_error_out        = mf;
	assign fault_vector_out         = vec;
	assign simd_rd_data_out         = rd_data_out[63:0];
	assign feature_general_reg_d_out =
		32'h0000_0001 << sfsa_pkg::FEAT_SIMD_BIT;

	////////////////////////////////////////////////////////////////////////

	sequence s_simd_ok;
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_SIMD
			&& req_supported_in && !fpu_emulation_flag_in
			&& !fp_exc_pending_in;
	endsequence

	sequence s_empty_ok;
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_EMPTY
			&& req_supported_in && !fpu_emulation_flag_in
			&& !fp_exc_pending_in;
	endsequence

	property p_tags_valid;
		@(posedge mclk_in) disable iff (!rstn_in)
		s_simd_ok |=> tag_word_out == 16'h0000 && done_out;
	endproperty
	a_tags_valid: assert property (p_tags_valid)
		else $error("tags not valid after simd op");

	property p_tags_empty;
		@(posedge mclk_in) disable iff (!rstn_in)
		s_empty_ok |=> tag_word_out == 16'hFFFF;
	endproperty
	a_tags_empty: assert property (p_tags_empty)
		else $error("tags not empty after empty-state op");

	property p_tos_zero;
		@(posedge mclk_in) disable iff (!rstn_in)
		s_simd_ok |=> stack_top_pointer_out == 3'h0;
	endproperty
	a_tos_zero: assert property (p_tos_zero)
		else $error("stack top not cleared");

	property p_exp_ones;
		@(posedge mclk_in) disable iff (!rstn_in)
		(s_simd_ok and simd_wr_in && rd_idx_in == simd_idx_in)
			##1 $stable(rd_idx_in) |->
			rd_data_out[79:64] == 16'hFFFF
			&& simd_rd_data_out == $past(simd_data_in);
	endproperty
	a_exp_ones: assert property (p_exp_ones)
		else $error("simd write did not alias correctly");

	property p_fp_as_found;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_FP
			&& !fp_state_wr_in |=> $stable(tag_word_out)
			&& $stable(stack_top_pointer_out);
	endproperty
	a_fp_as_found: assert property (p_fp_as_found)
		else $error("fp op altered stack state");

	property p_emu_ud;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_SIMD
			&& fpu_emulation_flag_in |=> invalid_opcode_fault_out
			&& fault_vector_out == 8'h06 && $stable(tag_word_out);
	endproperty
	a_emu_ud: assert property (p_emu_ud)
		else $error("emulation did not fault");

	property p_unsup_ud;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && (req_op_in == sfsa_pkg::SFSA_OP_EMPTY
			|| req_op_in == sfsa_pkg::SFSA_OP_SIMD)
			&& !req_supported_in |=> invalid_opcode_fault_out
			&& !done_out;
	endproperty
	a_unsup_ud: assert property (p_unsup_ud)
		else $error("unsupported op did not fault");

	property p_feature;
		@(posedge mclk_in) disable iff (!rstn_in)
		feature_general_reg_d_out[23] == 1'b1;
	endproperty
	a_feature: assert property (p_feature)
		else $error("feature bit missing");

	property p_numeric;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_SIMD
			&& req_supported_in && !fpu_emulation_flag_in
			&& fp_exc_pending_in |=> numeric_error_out
			&& fault_vector_out == 8'h10 && !done_out;
	endproperty
	a_numeric: assert property (p_numeric)
		else $error("pending exception did not trap");

	sequence s_simd_refused;
		req_valid_in && (req_op_in == sfsa_pkg::SFSA_OP_SIMD
			|| req_op_in == sfsa_pkg::SFSA_OP_EMPTY)
			&& (fpu_emulation_flag_in || !req_supported_in);
	endsequence

	sequence s_trap_pending;
		req_valid_in && (req_op_in == sfsa_pkg::SFSA_OP_SIMD
			|| req_op_in == sfsa_pkg::SFSA_OP_EMPTY)
			&& req_supported_in && !fpu_emulation_flag_in
			&& fp_exc_pending_in;
	endsequence

	property p_refused_keeps;
		@(posedge mclk_in) disable iff (!rstn_in)
		s_simd_refused |=> $stable(tag_word_out)
			&& $stable(stack_top_pointer_out) && !done_out;
	endproperty
	a_refused_keeps: assert property (p_refused_keeps)
		else $error("refused op changed stack state");

	// a refused op must not reach the shared array either
	property p_refused_no_write;
		@(posedge mclk_in) disable iff (!rstn_in)
		(s_simd_refused and rd_idx_in == simd_idx_in)
			##1 $stable(rd_idx_in) |-> $stable(rd_data_out);
	endproperty
	a_refused_no_write: assert property (p_refused_no_write)
		else $error("refused op wrote a register");

	property p_trap_keeps;
		@(posedge mclk_in) disable iff (!rstn_in)
		s_trap_pending |=> $stable(tag_word_out)
			&& $stable(stack_top_pointer_out);
	endproperty
	a_trap_keeps: assert property (p_trap_keeps)
		else $error("trapped op changed stack state");

	property p_fp_load;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_FP
			&& fp_state_wr_in |=> tag_word_out == $past(fp_tag_in)
			&& stack_top_pointer_out == $past(fp_tos_in);
	endproperty
	a_fp_load: assert property (p_fp_load)
		else $error("fp state not taken as given");

	property p_fp_write;
		@(posedge mclk_in) disable iff (!rstn_in)
		(req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_FP && fp_wr_in
			&& rd_idx_in == fp_idx_in) ##1 $stable(rd_idx_in)
			|-> rd_data_out == $past(fp_data_in);
	endproperty
	a_fp_write: assert property (p_fp_write)
		else $error("fp write did not reach shared array");

	property p_save_keeps;
		@(posedge mclk_in) disable iff (!rstn_in)
		req_valid_in && req_op_in == sfsa_pkg::SFSA_OP_SAVE
			|=> $stable(tag_word_out)
			&& $stable(stack_top_pointer_out) && done_out;
	endproperty
	a_save_keeps: assert property (p_save_keeps)
		else $error("save op changed stack state");

	property p_one_outcome;
		@(posedge mclk_in) disable iff (!rstn_in)
		$onehot0({done_out, invalid_opcode_fault_out, numeric_error_out});
	endproperty
	a_one_outcome: assert property (p_one_outcome)
		else $error("more than one outcome pulse");
endmodule

// [verification/sfsa_pipe_model.sv]
// execution pipeline model: issues one request at a time to the alias block
// assumes the bench calls issue() and the block answers one edge later
module sfsa_pipe_model (
	input  wire logic        mclk_in,
	output logic             req_valid_out,
	output logic      [2:0]  req_op_out,
	output logic             req_supported_out,
	output logic             simd_wr_out,
	output logic      [2:0]  simd_idx_out,
	output logic      [63:0] simd_data_out,
	output logic             fp_wr_out,
	output logic      [2:0]  fp_idx_out,
	output logic      [79:0] fp_data_out,
	output logic      [15:0] fp_tag_out,
	output logic      [2:0]  fp_tos_out,
	output logic             fp_state_wr_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{req_valid_out, req_op_out, req_supported_out, simd_wr_out} = '0;
		{simd_idx_out, simd_data_out, fp_wr_out, fp_idx_out} = '0;
		{fp_data_out, fp_tag_out, fp_tos_out, fp_state_wr_out} = '0;
	end
	////////////////////////////////////////////////////////////////////////
	// held over one rising edge; payload inverted after so stale data shows
	task automatic issue(input logic [2:0] op, input logic sup,
			input logic [2:0] idx, input logic [79:0] d,
			input logic [15:0] tag, input logic [2:0] stack_top_pointer,
			input logic st = 1'b1);
		@(negedge mclk_in);
		req_valid_out = 1'b1;
		req_op_out = op;
		req_supported_out = sup;
		simd_wr_out = (op == 3'h1);
		fp_wr_out = (op == 3'h3);
		fp_state_wr_out = (op == 3'h3) && st;
		{simd_idx_out, fp_idx_out} = {idx, idx};
		simd_data_out = d[63:0];
		fp_data_out = d;
		{fp_tag_out, fp_tos_out} = {tag, stack_top_pointer};
		@(negedge mclk_in);
		{req_valid_out, simd_wr_out, fp_wr_out, fp_state_wr_out} = '0;
		simd_data_out = ~simd_data_out;
		fp_data_out = ~fp_data_out;
	endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the simd / floating-point alias state block
// assumes the pipeline model drives requests on the falling edge
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk_in = 1'b0;
	logic        rstn_in = 1'b0;
	logic        emu = 1'b0;
	logic        exc = 1'b0;
	logic [2:0]  rd_idx = 3'h0;
	logic        v, sup, swr, fwr, fst, done, ud, num;
	logic [2:0]  op, sidx, fidx, ftos, stack_top_pointer;
	logic [63:0] sdat, srd;
	logic [79:0] fdat, rd;
	logic [15:0] ftag, tag;
	logic [7:0]  vec;
	logic [31:0] feat;
	int          fails = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	localparam logic [63:0] SD = 64'hDEAD_BEEF_0123_4567;
	localparam logic [79:0] FD = 80'h4001_A5A5_0000_1111_2222;

	sfsa_pipe_model pipe (.mclk_in(mclk_in), .req_valid_out(v),
		.req_op_out(op), .req_supported_out(sup), .simd_wr_out(swr),
		.simd_idx_out(sidx), .simd_data_out(sdat), .fp_wr_out(fwr),
		.fp_idx_out(fidx), .fp_data_out(fdat), .fp_tag_out(ftag),
		.fp_tos_out(ftos), .fp_state_wr_out(fst));
	sfsa_top DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_valid_in(v),
		.req_op_in(op), .req_supported_in(sup), .simd_wr_in(swr),
		.simd_idx_in(sidx), .simd_data_in(sdat), .fp_wr_in(fwr),
		.fp_idx_in(fidx), .fp_data_in(fdat), .fp_tag_in(ftag),
		.fp_tos_in(ftos), .fp_state_wr_in(fst),
		.fpu_emulation_flag_in(emu), .fp_exc_pending_in(exc),
		.rd_idx_in(rd_idx), .rd_data_out(rd), .simd_rd_data_out(srd),
		.tag_word_out(tag), .stack_top_pointer_out(stack_top_pointer),
		.done_out(done), .invalid_opcode_fault_out(ud),
		.numeric_error_out(num), .fault_vector_out(vec),
		.feature_general_reg_d_out(feat));

	initial begin
		forever #20 mclk_in = ~mclk_in;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [127:0] got, input logic [127:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// cut a hang short; whole run needs well under 100 cycles
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			end_sim;
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		chk(tag, 16'hFFFF);
		chk(stack_top_pointer, 3'h0);
		chk(feat, 32'h0080_0000);
		$display("reset test done");
	endtask

	task automatic t_fp_then_simd;
		pipe.issue(3'h3, 1'b1, 3'h1, FD, 16'h5A5A, 3'h5);
		rd_idx = 3'h1;
		#1 chk({done, tag, stack_top_pointer, rd}, {1'b1, 16'h5A5A, 3'h5, FD});
		rd_idx = 3'h2;
		pipe.issue(3'h1, 1'b1, 3'h2, {16'h0000, SD}, 16'h0000, 3'h0);
		chk({done, ud, num}, 3'h4);
		chk(tag, 16'h0000);
		chk(stack_top_pointer, 3'h0);
		rd_idx = 3'h2;
		#1 chk(rd, {16'hFFFF, SD});
		chk(srd, SD);
		rd_idx = 3'h1;
		#1 chk(rd, FD);
		$display("fp and simd test done");
	endtask

	// software side: save the simd data, then empty before fp code
	task automatic t_save_empty;
		pipe.issue(3'h4, 1'b1, 3'h2, 80'h0, 16'h0000, 3'h0);
		rd_idx = 3'h2;
		#1 chk({done, rd}, {1'b1, 16'hFFFF, SD});
		pipe.issue(3'h2, 1'b1, 3'h0, 80'h0, 16'h0000, 3'h0);
		chk({done, tag}, {1'b1, 16'hFFFF});
		// fp op with no state load must leave tags and stack top alone
		rd_idx = 3'h3;
		pipe.issue(3'h3, 1'b1, 3'h3, FD, 16'h1234, 3'h6, 1'b0);
		chk({done, tag, stack_top_pointer}, {1'b1, 16'hFFFF, 3'h0});
		#1 chk(rd, FD);
		$display("save and empty test done");
	endtask

	task automatic t_faults;
		@(negedge mclk_in);
		emu = 1'b1;
		pipe.issue(3'h1, 1'b1, 3'h3, {16'h0, SD}, 16'h0000, 3'h0);
		chk({done, ud, num, vec, tag}, {3'h2, 8'h06, 16'hFFFF});
		emu = 1'b0;
		pipe.issue(3'h1, 1'b0, 3'h3, {16'h0, SD}, 16'h0000, 3'h0);
		chk({done, ud, num, tag}, {3'h2, 16'hFFFF});
		exc = 1'b1;
		pipe.issue(3'h1, 1'b1, 3'h3, {16'h0, SD}, 16'h0000, 3'h0);
		chk({done, ud, num, vec, tag}, {3'h1, 8'h10, 16'hFFFF});
		exc = 1'b0;
		#1 chk(rd, FD);
		$display("fault test done");
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge mclk_in);
		@(negedge mclk_in);
		rstn_in = 1'b1;
		t_reset;
		t_fp_then_simd;
		t_save_empty;
		t_faults;
		end_sim;
	end
endmodule
